// *** inc/ccl_pkg.sv ***
package ccl_pkg;
  // descriptor tags and lengths
  localparam logic [7:0] TAG_CONV_CAL   = 8'h13;
  localparam logic [7:0] LEN_CONV_CAL   = 8'h10;
  localparam logic [7:0] TAG_LOADER     = 8'h1C;
  localparam logic [7:0] LEN_LOADER     = 8'h02;
  localparam logic [7:0] TAG_EXT_LAST   = 8'hFD;
  localparam logic [7:0] TAG_EXTENDER   = 8'hFE;
  // loader link selection codes, unused settings byte value and I2C address limit
  localparam logic [7:0] LINK_UART      = 8'h00;
  localparam logic [7:0] LINK_I2C       = 8'h01;
  localparam logic [7:0] UNUSED_BYTE    = 8'h00;
  localparam logic [7:0] ADDR_MAX       = 8'h7F;
  // calibration record byte positions after the length byte
  localparam int         POS_GAIN       = 0;
  localparam int         POS_OFFSET     = 2;
  localparam int         POS_REF1       = 4;
  localparam int         REF_STRIDE     = 4;
  // arithmetic constants
  localparam int         GAIN_SHIFT     = 15;
  localparam int         TEMP_LOW_C     = 30;
  localparam int         TEMP_HIGH_C    = 85;
  localparam int         TEMP_SPAN_C    = TEMP_HIGH_C - TEMP_LOW_C;
  // walker states
  typedef enum logic [2:0] {
    CCL_IDLE, CCL_TAG, CCL_LEN, CCL_BODY, CCL_SKIP, CCL_DONE
  } ccl_state_t;
endpackage

// *** src/ccl_core.sv ***
// Contract
// (RULE_01) calibration record: tag 13h, length 10h
// (RULE_02) offset is signed, added to result
// (RULE_03) gain: multiply by coefficient, scale 2^15
// (RULE_04) gain applied first, then offset
// (RULE_05) two sensor points per reference, 30/85
// (RULE_06) sensor voltage linear in temperature
// (RULE_07) temp = (raw-low)*55/(high-low)+30
// (RULE_08) loader record: tag 1Ch, select then settings
// (RULE_09) loader length from length byte, 02h
// (RULE_10) select 00h UART, 01h I2C, rest reserved
// (RULE_11) settings0: 00h UART, I2C 7-bit address
// (RULE_12) unused settings bytes must be 00h
// (RULE_13) loader record is read-only
// (RULE_14) absent loader record means UART only
// (RULE_15) one-byte length; FEh has extension, two-byte length
// (RULE_16) 2^15 scaling is arithmetic shift, truncated
// (RULE_17) equal points flag error, no divide
module ccl_core
  import ccl_pkg::*;
#(
  parameter int ADDR_W = 12,                // descriptor address width
  parameter int RAW_W  = 10                 // converter result width
) (
  input  wire logic              clk_in,            // 50 MHz clock
  input  wire logic              rst_in,            // async reset, high
  input  wire logic              scan_start_in,     // pulse: walk table
  input  wire logic [ADDR_W-1:0] table_base_in,     // first tag address
  input  wire logic [ADDR_W-1:0] table_end_in,      // address past table
  output logic      [ADDR_W-1:0] mem_addr_out,      // descriptor address
  input  wire logic [7:0]        mem_data_in,       // byte, next cycle
  output logic                   scan_busy_out,     // walk in progress
  output logic                   scan_done_out,     // walk finished
  output logic                   cal_found_out,     // calibration seen
  output logic                   cal_len_err_out,   // bad cal length
  input  wire logic              conv_valid_in,     // raw result pulse
  input  wire logic [RAW_W-1:0]  conv_raw_in,       // raw result
  input  wire logic              gain_en_in,        // apply gain
  input  wire logic              offset_en_in,      // apply offset
  input  wire logic [1:0]        ref_sel_in,        // reference 0..2
  output logic                   corr_valid_out,    // corrected pulse
  output logic signed [31:0]     corr_out,          // corrected result
  output logic signed [31:0]     temp_out,          // degrees C
  output logic                   temp_err_out,      // equal points
  output logic      [7:0]        loader_link_select_out,   // interface
  output logic      [7:0]        loader_link_settings_out, // settings 0
  output logic      [7:0]        loader_len_out,    // record length
  output logic                   loader_found_out,  // record present
  output logic                   loader_err_out     // bad loader record
);
  // refuse widths that the walker or datapath cannot serve
  if (ADDR_W < 4 || ADDR_W > 16 ||
      RAW_W < 1 || RAW_W > 16) begin : g_bad_param
    $error("unsupported parameter");
  end

  // all checks run on the one clock and rest during reset
  default clocking cb_chk @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  ccl_state_t        st_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        tag_r;
  logic [15:0]       len_r;
  logic [15:0]       idx_r;
  logic [1:0]        hdr_r;
  logic              ext_r;
  logic [7:0]        cal_r [16];
  logic              rd_r;

  function automatic logic [15:0] cal_word(input int pos);
    return {cal_r[pos+1], cal_r[pos]};
  endfunction

  // address out and walk status; there is no write path
  assign mem_addr_out  = addr_r;                     // RULE_13
  assign scan_busy_out = (st_r != CCL_IDLE) && (st_r != CCL_DONE);
  assign scan_done_out = (st_r == CCL_DONE);         // walk reached end

  // table walker; record fields are only ever read, never written (RULE_13)
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r   <= CCL_IDLE;
      addr_r <= '0;
      tag_r  <= 8'h00;
      len_r  <= 16'h0000;
      idx_r  <= 16'h0000;
      hdr_r  <= 2'd0;
      ext_r  <= 1'b0;
      rd_r   <= 1'b0;
    end else begin
      rd_r <= 1'b0;
      unique case (st_r)
        CCL_IDLE, CCL_DONE: begin
          if (scan_start_in) begin
            addr_r <= table_base_in;
            rd_r   <= 1'b1;
            st_r   <= CCL_TAG;
          end
        end
        CCL_TAG: begin
          if (!rd_r) begin
            if (addr_r >= table_end_in) begin
              st_r <= CCL_DONE;
            end else begin
              tag_r  <= mem_data_in;
              ext_r  <= (mem_data_in == TAG_EXTENDER); // RULE_15
              hdr_r  <= 2'd0;
              len_r  <= 16'h0000;
              addr_r <= addr_r + 1'b1;
              rd_r   <= 1'b1;
              st_r   <= CCL_LEN;
            end
          end
        end
        CCL_LEN: begin
          if (!rd_r) begin
            addr_r <= addr_r + 1'b1;
            rd_r   <= 1'b1;
            idx_r  <= 16'h0000;
            if (!ext_r) begin
              len_r <= {8'h00, mem_data_in};              // RULE_15
              st_r  <= (mem_data_in == 8'h00) ? CCL_TAG : CCL_BODY;
            end else begin
              hdr_r <= hdr_r + 2'd1;                      // RULE_15
              if (hdr_r == 2'd1) len_r[7:0] <= mem_data_in;
              if (hdr_r == 2'd2) begin
                len_r[15:8] <= mem_data_in;
                st_r <= ({mem_data_in, len_r[7:0]} == 16'h0000) ?
                        CCL_TAG : CCL_BODY;
              end
            end
          end
        end
        CCL_BODY: begin
          if (!rd_r) begin
            idx_r  <= idx_r + 16'h0001;
            addr_r <= addr_r + 1'b1;
            rd_r   <= 1'b1;
            if (idx_r + 16'h0001 == len_r) st_r <= CCL_TAG;
          end
        end
        default: st_r <= CCL_IDLE;
      endcase
    end
  end

  logic body_byte;
  assign body_byte = (st_r == CCL_BODY) && !rd_r;

  // capture calibration record bytes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 16; i++) cal_r[i] <= 8'h00;
      cal_found_out   <= 1'b0;
      cal_len_err_out <= 1'b0;
    end else begin
      if (scan_start_in && !scan_busy_out) begin
        cal_found_out   <= 1'b0;
        cal_len_err_out <= 1'b0;
      end
      if (st_r == CCL_LEN && !rd_r && !ext_r && tag_r == TAG_CONV_CAL) begin
        cal_found_out   <= (mem_data_in == LEN_CONV_CAL);    // RULE_01
        cal_len_err_out <= (mem_data_in != LEN_CONV_CAL);    // RULE_01
      end
      if (body_byte && tag_r == TAG_CONV_CAL && len_r == 16'(LEN_CONV_CAL))
        cal_r[idx_r[3:0]] <= mem_data_in;                    // RULE_05
    end
  end

  // loader record decode; absent record defaults to UART (RULE_14)
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      loader_link_select_out   <= LINK_UART;
      loader_link_settings_out <= UNUSED_BYTE;
      loader_len_out           <= 8'h00;
      loader_found_out         <= 1'b0;
      loader_err_out           <= 1'b0;
    end else begin
      if (scan_start_in && !scan_busy_out) begin
        loader_link_select_out   <= LINK_UART;               // RULE_14
        loader_link_settings_out <= UNUSED_BYTE;
        loader_len_out           <= 8'h00;
        loader_found_out         <= 1'b0;
        loader_err_out           <= 1'b0;
      end
      if (st_r == CCL_LEN && !rd_r && !ext_r && tag_r == TAG_LOADER) begin
        loader_found_out <= 1'b1;                            // RULE_08
        loader_len_out   <= mem_data_in;                     // RULE_09
        if (mem_data_in != LEN_LOADER) loader_err_out <= 1'b1;
      end
      if (body_byte && tag_r == TAG_LOADER) begin
        if (idx_r == 16'h0000) begin
          loader_link_select_out <= mem_data_in;             // RULE_08
          if (mem_data_in > LINK_I2C) loader_err_out <= 1'b1; // RULE_10
        end else if (idx_r == 16'h0001) begin
          loader_link_settings_out <= mem_data_in;           // RULE_11
          if (loader_link_select_out == LINK_UART &&
              mem_data_in != UNUSED_BYTE) loader_err_out <= 1'b1;
          if (loader_link_select_out == LINK_I2C &&
              mem_data_in > ADDR_MAX) loader_err_out <= 1'b1; // RULE_11
        end else if (mem_data_in != UNUSED_BYTE) begin
          loader_err_out <= 1'b1;                            // RULE_12
        end
      end
    end
  end

  // correction and temperature datapath
  logic signed [16:0] raw_s;
  logic signed [33:0] prod;
  logic signed [31:0] gained;
  logic signed [31:0] offs;
  logic signed [17:0] low_pt;
  logic signed [17:0] high_pt;
  logic signed [17:0] span;
  logic signed [31:0] dnum;
  int                 rp;

  always_comb begin
    raw_s   = 17'(conv_raw_in);
    prod    = 34'(raw_s) * 34'($signed({1'b0, cal_word(POS_GAIN)}));
    gained  = gain_en_in ? 32'(prod >>> GAIN_SHIFT)          // RULE_03 RULE_16
                         : 32'(raw_s);
    offs    = 32'($signed(cal_word(POS_OFFSET)));            // RULE_02
    rp      = POS_REF1 + REF_STRIDE * int'(ref_sel_in);
    if (ref_sel_in == 2'd3) rp = POS_REF1;
    low_pt  = 18'($signed({1'b0, cal_word(rp)}));            // RULE_05
    high_pt = 18'($signed({1'b0, cal_word(rp + 2)}));        // RULE_05
    span    = high_pt - low_pt;                              // RULE_06
    dnum    = 32'(raw_s) - 32'(low_pt);
  end

  // registered outputs; gain then offset (RULE_04)
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      corr_valid_out <= 1'b0;
      corr_out       <= '0;
      temp_out       <= '0;
      temp_err_out   <= 1'b0;
    end else begin
      corr_valid_out <= conv_valid_in;
      if (conv_valid_in) begin
        corr_out <= offset_en_in ? gained + offs : gained;   // RULE_04
        if (span == 18'sd0) begin
          temp_err_out <= 1'b1;                              // RULE_17
          temp_out     <= '0;
        end else begin
          temp_err_out <= 1'b0;
          temp_out <= (dnum * TEMP_SPAN_C) / 32'(span)       // RULE_07
                      + TEMP_LOW_C;
        end
      end
    end
  end

  // steps that start a walk or a conversion
  sequence s_walk_start;
    scan_start_in && !scan_busy_out;
  endsequence
  sequence s_conv_plain;
    conv_valid_in && !gain_en_in && !offset_en_in;
  endsequence
  sequence s_conv_offset;
    conv_valid_in && !gain_en_in && offset_en_in;
  endsequence

  // result timing and arithmetic
  chk_corr_order: assert property ( // RULE_04
    conv_valid_in |=> corr_valid_out) else $error("no corrected result");
  chk_span_zero: assert property ( // RULE_17
    conv_valid_in && span == 0 |=> temp_err_out)
    else $error("equal points not flagged");
  chk_raw_pass: assert property ( // RULE_04
    s_conv_plain |=> corr_out == 32'($past(conv_raw_in)))
    else $error("uncorrected result altered");
  chk_offset_add: assert property ( // RULE_02
    s_conv_offset |=> corr_out == 32'($past(conv_raw_in)) +
      32'($signed({cal_r[POS_OFFSET + 1], cal_r[POS_OFFSET]})))
    else $error("offset not added");

  // walk start clears the decode; a clean loader record stays in range
  chk_walk_start: assert property ( // RULE_15
    s_walk_start |=> scan_busy_out) else $error("walk did not start");
  chk_decode_clear: assert property ( // RULE_14
    s_walk_start |=> !loader_found_out && !cal_found_out &&
      loader_link_select_out == LINK_UART)
    else $error("stale record state");
  chk_link_code: assert property ( // RULE_10
    loader_found_out && !loader_err_out && !scan_busy_out |->
      loader_link_select_out <= LINK_I2C)
    else $error("reserved link accepted");
  chk_link_addr: assert property ( // RULE_11
    loader_found_out && !loader_err_out && !scan_busy_out &&
      loader_link_select_out == LINK_I2C |->
      loader_link_settings_out <= ADDR_MAX)
    else $error("slave address out of range");
endmodule

// *** tb/ccl_core_tb_top.sv ***
module ccl_core_tb_top;
  import ccl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, start = 1'b0, cv = 1'b0, done;
  logic ge = 1'b0, oe = 1'b0, busy, cvo, terr, cfound, clerr, lfound, lerr;
  logic [1:0] rs = 2'h0;
  logic [9:0] raw = 10'h000;
  logic [11:0] tend = 12'h000, maddr;
  logic [7:0] mdata, lsel, lset, llen;
  logic signed [31:0] corr, temp;
  int n_mismatch = 0, check_count = 0;
  ccl_core u_dut (.clk_in(clk_in), .rst_in(rst_in), .scan_start_in(start),
    .table_base_in(12'h000), .table_end_in(tend), .mem_addr_out(maddr),
    .mem_data_in(mdata), .scan_busy_out(busy), .scan_done_out(done),
    .cal_found_out(cfound), .cal_len_err_out(clerr), .conv_valid_in(cv),
    .conv_raw_in(raw), .gain_en_in(ge), .offset_en_in(oe), .ref_sel_in(rs),
    .corr_valid_out(cvo), .corr_out(corr), .temp_out(temp),
    .temp_err_out(terr), .loader_link_select_out(lsel),
    .loader_link_settings_out(lset), .loader_len_out(llen),
    .loader_found_out(lfound), .loader_err_out(lerr));
  ccl_mem_model u_mem (.clk_in(clk_in), .addr_in(maddr), .data_out(mdata));
  // 50 MHz clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task automatic test_done();
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  // calibration record then loader record
  task automatic fill(input logic [7:0] sel, set, clen);
    logic [7:0] img [0:21];
    img = '{8'h13, clen, 8'hEE, 8'h7F, 8'hFB, 8'hFF, 8'h00, 8'h01,
      8'h80, 8'h01, 8'h00, 8'h02, 8'h37, 8'h02, 8'h00, 8'h03, 8'h00,
      8'h03, 8'h1C, 8'h02, sel, set};
    for (int i = 0; i < 22; i++) u_mem.mem_r[i] = img[i];
  endtask
  // start a walk and wait until it ends
  task automatic scan(input logic [11:0] e);
    int k;
    @(posedge clk_in);
    tend <= e;
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    #1;
    check(busy, 1'b1);
    for (k = 0; k < 400 && busy !== 1'b0; k++) begin
      @(posedge clk_in);
      #1;
    end
    check(busy, 1'b0);
    check(done, 1'b1);
  endtask
  // loader variants: select, settings, error expected; raw results for the correction runs
  logic [7:0] vsel [5] = '{8'h01, 8'h00, 8'h01, 8'h02, 8'h00};
  logic [7:0] vset [5] = '{8'h5A, 8'h00, 8'h80, 8'h00, 8'h11};
  logic       verr [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [9:0] craw [5] = '{10'h150, 10'h100, 10'h000, 10'h3FF, 10'h100};
  // extended-tag record with two-byte length, then a second loader record
  logic [7:0] xt [10] = '{8'hFE, 8'h05, 8'h02, 8'h00, 8'hAA, 8'h55,
    8'h1C, 8'h02, 8'h01, 8'h33};
  int lo [3] = '{256, 512, 768};
  int hi [3] = '{384, 567, 768};
  initial begin
    int r, c, q;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check(lsel, LINK_UART);
    check(lfound, 1'b0);
    for (int v = 0; v < 5; v++) begin
      fill(vsel[v], vset[v], LEN_CONV_CAL);
      scan(12'd22);
      check(cfound, 1'b1);
      check(lfound, 1'b1);
      check(llen, LEN_LOADER);
      check(lerr, verr[v]);
      if (!verr[v]) check(lsel, vsel[v]);
      if (!verr[v]) check(lset, vset[v]);
    end
    // corrections and temperature on each reference, code 3 as the last
    for (int i = 0; i < 5; i++) begin
      r = (i == 0) ? 2 : (i == 4) ? 3 : i - 1;
      q = (r == 3) ? 0 : r;
      @(posedge clk_in);
      raw <= craw[i];
      ge <= i[0];
      oe <= i[1];
      rs <= r[1:0];
      cv <= 1'b1;
      @(posedge clk_in);
      cv <= 1'b0;
      #1;
      c = i[0] ? (int'(craw[i]) * 32750) >>> 15 : int'(craw[i]);
      c = i[1] ? c - 5 : c;
      check(cvo, 1'b1);
      check(corr, c);
      check(terr, r == 2);
      c = (int'(craw[i]) - lo[q]) * 55 / (hi[q] - lo[q]) + 30;
      if (r != 2) check(temp, c);
      @(posedge clk_in);
      #1;
      check(cvo, 1'b0);
    end
    scan(12'h012);
    check(lfound, 1'b0);
    check(lsel, LINK_UART);
    // extended tag skipped by its two-byte length, then a loader record
    fill(8'h00, 8'h00, LEN_CONV_CAL);
    for (int j = 0; j < 10; j++) u_mem.mem_r[22 + j] = xt[j];
    scan(12'h020);
    check(lfound, 1'b1);
    check(lsel, LINK_I2C);
    check(lset, 8'h33);
    check(lerr, 1'b0);
    fill(8'h00, 8'h00, 8'h0F);
    scan(12'h016);
    check(clerr, 1'b1);
    check(cfound, 1'b0);
    test_done();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    test_done();
  end
endmodule

// *** tb/ccl_mem_model.sv ***
module ccl_mem_model #(
  parameter int ADDR_W = 12                // descriptor address width
) (
  input  wire logic              clk_in,   // memory clock
  input  wire logic [ADDR_W-1:0] addr_in,  // byte address
  output logic      [7:0]        data_out  // byte, one cycle later
);
  timeunit 1ns;
  timeprecision 1ps;
  // descriptor bytes, loaded by the bench only; no write port exists
  logic [7:0] mem_r [0:63];
  // registered read, so records come back one byte per request
  always_ff @(posedge clk_in) begin
    data_out <= mem_r[addr_in[5:0]];
  end
endmodule
